// [hw/idle_pkg.sv]
package idle_pkg;
  // Power-save control field positions
  localparam int          MWAKE_MASK_BIT   = 0;
  localparam int          NMWAKE_MASK_BIT  = 1;
  localparam int          IDLE_REQ_BIT     = 2;
  localparam logic [7:0]  CTRL_RESET       = 8'h00;
  localparam logic [7:0]  MODE_RESET       = 8'h00;
  localparam logic [7:0]  MODE_IDLE_CODE   = 8'h01;
  localparam int          NUM_WAKE_IRQ     = 3;
  localparam logic [3:0]  PRIO_NONE        = 4'hf;
  localparam logic [3:0]  PRIO_NMI         = 4'h0;
  localparam int          SYNC_STAGES      = 2;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_IDLE,
    PWR_WAKE
  } pwr_state_t;
endpackage : idle_pkg

// [hw/wake_detect.sv]
`timescale 1ns/1ps
// Runs on the free clock; wake inputs are level requests.
module wake_detect (
  input  wire logic                            core_clk,
  input  wire logic                            resetn,
  input  wire logic                            nmi_req,
  input  wire logic [idle_pkg::NUM_WAKE_IRQ-1:0] external_wake_irq_inputs,
  input  wire logic [idle_pkg::NUM_WAKE_IRQ-1:0] irq_unmasked,
  output logic                                 nmi_seen,
  output logic [idle_pkg::NUM_WAKE_IRQ-1:0]    irq_seen
);
  typedef struct packed {
    logic                            nmi_r;
    logic [idle_pkg::NUM_WAKE_IRQ-1:0] irq_r;
  } wd_t;
  wd_t wd_r;
  wd_t wd_nxt;

  always_comb begin
    wd_nxt       = wd_r;
    wd_nxt.nmi_r = nmi_req;
    wd_nxt.irq_r = external_wake_irq_inputs & irq_unmasked;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wd_r <= '0;
    end else begin
      wd_r <= wd_nxt;
    end
  end

  assign nmi_seen = wd_r.nmi_r;
  assign irq_seen = wd_r.irq_r;
endmodule : wake_detect

// [hw/idle_mode_power_controller.sv]
`timescale 1ns/1ps
// Behaviour
// - Clock generator runs, system clock gated
// - Exit with no stabilisation wait
// - Control or mode register write enters idle
// - CPU halted, all state retained
// - Defined bus pin states during idle
// - Wake on NMI, unmasked irq, reset
// - Interrupt wake only if masks cleared
// - Wake regardless of priority
// - Lower priority wakes, stays pending
// - Higher priority wakes and is acknowledged (here only with irq_enabled_state set, else it stays pending)
// - Branch or next instruction after wake
// - Idle in NMI service: wake, no acknowledge
// - Reset exit equals ordinary reset
module idle_mode_power_controller (
  input  wire logic                              core_clk,
  input  wire logic                              resetn,
  // CPU register write port
  input  wire logic                              ctrl_wr,
  input  wire logic                              mode_wr,
  input  wire logic [7:0]                        wr_data,
  output logic [7:0]                             power_save_control_reg,
  output logic [7:0]                             power_save_mode_reg,
  // Interrupt side
  input  wire logic                              nmi_req,
  input  wire logic [idle_pkg::NUM_WAKE_IRQ-1:0] external_wake_irq_inputs,
  input  wire logic [idle_pkg::NUM_WAKE_IRQ-1:0] irq_unmasked,
  input  wire logic [idle_pkg::NUM_WAKE_IRQ*4-1:0] irq_prio,
  input  wire logic [3:0]                        cur_service_prio,
  input  wire logic                              in_maskable_service,
  input  wire logic                              in_nmi_service,
  input  wire logic                              irq_enabled_state,
  output logic                                   wake_ack,
  output logic                                   wake_ack_nmi,
  output logic [1:0]                             wake_ack_idx,
  output logic                                   wake_branch,
  output logic                                   wake_pending,
  // Clock control
  output logic                                   osc_pll_enable,
  output logic                                   sys_clk_enable,
  output logic                                   cpu_halt,
  output logic                                   idle_active,
  // Pin control during idle
  output logic                                   bus_float,
  output logic                                   strobes_force_high,
  output logic                                   hold_ack_force_high,
  output logic                                   hold_wait_ignore,
  output logic                                   sdram_ctl_keep_running,
  output logic                                   sdram_clock_enable,
  output logic                                   sdram_clock_gate,
  output logic                                   system_clock_gate
);

  typedef struct packed {
    idle_pkg::pwr_state_t state_r;
    logic [7:0]           ctrl_r;
    logic [7:0]           mode_r;
    logic                 int_wake_ok_r;
    logic                 ack_r;
    logic                 ack_nmi_r;
    logic [1:0]           ack_idx_r;
    logic                 branch_r;
    logic                 pend_r;
  } ctl_t;
  ctl_t ctl_r;
  ctl_t ctl_nxt;

  logic                              nmi_seen;
  logic [idle_pkg::NUM_WAKE_IRQ-1:0] irq_seen;
  logic                              any_wake;
  logic                              hi_found;
  logic [1:0]                        hi_idx;
  logic [3:0]                        hi_prio;
  logic                              enter_req;
  logic                              entry_wake_ok;
  logic                              nmi_pends;
  logic                              irq_pends;

  // =====================================================
  // Wake detection
  // The detector sits on the ungated clock so it sees requests while idle.
  wake_detect wake_detect_i (
    .core_clk                 (core_clk),
    .resetn                   (resetn),
    .nmi_req                  (nmi_req),
    .external_wake_irq_inputs (external_wake_irq_inputs),
    .irq_unmasked             (irq_unmasked),
    .nmi_seen                 (nmi_seen),
    .irq_seen                 (irq_seen)
  );

  // =====================================================
  // Wake arbitration
  // Most urgent maskable request; lower number means higher priority.
  // The first request found is taken at any level, so the lowest level still wakes.
  always_comb begin
    hi_found = 1'b0;
    hi_idx   = 2'd0;
    hi_prio  = idle_pkg::PRIO_NONE;
    for (int i = 0; i < idle_pkg::NUM_WAKE_IRQ; i++) begin
      if (irq_seen[i] && (!hi_found || (irq_prio[i*4 +: 4] < hi_prio))) begin
        hi_found = 1'b1;
        hi_idx   = 2'(i);
        hi_prio  = irq_prio[i*4 +: 4];
      end
    end
  end

  assign any_wake = nmi_seen | hi_found;

  // In NMI service every wake pends; in maskable service only a strictly
  // higher level is taken, an equal one waits like a lower one.
  assign nmi_pends = in_nmi_service;
  assign irq_pends = in_maskable_service && !(hi_prio < cur_service_prio);

  // =====================================================
  // Entry decode
  // Store or bit instruction on either register is seen as one write strobe.
  assign enter_req = (ctrl_wr && wr_data[idle_pkg::IDLE_REQ_BIT]) ||
                     (mode_wr && (wr_data == idle_pkg::MODE_IDLE_CODE));

  // Masks are judged as they stand once the write lands, so a control write
  // that sets the request and the masks together is seen whole.
  always_comb begin
    entry_wake_ok = !ctl_r.ctrl_r[idle_pkg::MWAKE_MASK_BIT] &&
                    !ctl_r.ctrl_r[idle_pkg::NMWAKE_MASK_BIT];
    if (ctrl_wr) begin
      entry_wake_ok = !wr_data[idle_pkg::MWAKE_MASK_BIT] &&
                      !wr_data[idle_pkg::NMWAKE_MASK_BIT];
    end
  end

  // =====================================================
  // Control state
  always_comb begin
    ctl_nxt           = ctl_r;
    ctl_nxt.ack_r     = 1'b0;
    ctl_nxt.ack_nmi_r = 1'b0;
    ctl_nxt.branch_r  = 1'b0;
    ctl_nxt.pend_r    = 1'b0;
    if (ctrl_wr) begin
      ctl_nxt.ctrl_r = wr_data;
    end
    if (mode_wr) begin
      ctl_nxt.mode_r = wr_data;
    end
    case (ctl_r.state_r)
      idle_pkg::PWR_RUN: begin
        if (enter_req) begin
          ctl_nxt.state_r       = idle_pkg::PWR_IDLE;
          // Latched at entry; later changes cannot reopen wake.
          ctl_nxt.int_wake_ok_r = entry_wake_ok;
        end
      end
      idle_pkg::PWR_IDLE: begin
        if (ctl_r.int_wake_ok_r && any_wake) begin
          // No stabilisation wait: clocks reopen on the next edge.
          ctl_nxt.state_r = idle_pkg::PWR_WAKE;
          ctl_nxt.ctrl_r[idle_pkg::IDLE_REQ_BIT] = 1'b0;
          ctl_nxt.mode_r  = idle_pkg::MODE_RESET;
          if (nmi_pends) begin
            ctl_nxt.pend_r = 1'b1;
          end else if (nmi_seen) begin
            ctl_nxt.ack_r     = 1'b1;
            ctl_nxt.ack_nmi_r = 1'b1;
            ctl_nxt.branch_r  = 1'b1;
          end else if (irq_pends) begin
            ctl_nxt.pend_r = 1'b1;
          end else begin
            ctl_nxt.ack_r     = irq_enabled_state;
            ctl_nxt.ack_idx_r = hi_idx;
            ctl_nxt.branch_r  = irq_enabled_state;
            ctl_nxt.pend_r    = !irq_enabled_state;
          end
        end
      end
      default: begin
        ctl_nxt.state_r = idle_pkg::PWR_RUN;
      end
    endcase
  end

  // Reset exit goes through this same asynchronous reset path.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctl_r.state_r       <= idle_pkg::PWR_RUN;
      ctl_r.ctrl_r        <= idle_pkg::CTRL_RESET;
      ctl_r.mode_r        <= idle_pkg::MODE_RESET;
      ctl_r.int_wake_ok_r <= 1'b0;
      ctl_r.ack_r         <= 1'b0;
      ctl_r.ack_nmi_r     <= 1'b0;
      ctl_r.ack_idx_r     <= 2'd0;
      ctl_r.branch_r      <= 1'b0;
      ctl_r.pend_r        <= 1'b0;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  // =====================================================
  // Outputs
  assign idle_active            = (ctl_r.state_r == idle_pkg::PWR_IDLE);
  assign osc_pll_enable         = 1'b1;
  assign sys_clk_enable         = !idle_active;
  // Halting keeps CPU state in place; nothing is cleared here.
  assign cpu_halt               = idle_active;
  assign bus_float              = idle_active;
  assign strobes_force_high     = idle_active;
  assign hold_ack_force_high    = idle_active;
  assign hold_wait_ignore       = idle_active;
  assign sdram_ctl_keep_running = 1'b1;
  assign sdram_clock_enable     = !idle_active;
  assign sdram_clock_gate       = !idle_active;
  assign system_clock_gate      = !idle_active;
  assign power_save_control_reg = ctl_r.ctrl_r;
  assign power_save_mode_reg    = ctl_r.mode_r;
  assign wake_ack               = ctl_r.ack_r;
  assign wake_ack_nmi           = ctl_r.ack_nmi_r;
  assign wake_ack_idx           = ctl_r.ack_idx_r;
  assign wake_branch            = ctl_r.branch_r;
  assign wake_pending           = ctl_r.pend_r;
endmodule : idle_mode_power_controller

// [tb/idle_chk.sv]
`timescale 1ns/1ps
// ==========
// Idle checks
module idle_chk (
  input logic       core_clk,
  input logic       resetn,
  input logic       ctrl_wr,
  input logic       mode_wr,
  input logic [7:0] wr_data,
  input logic       nmi_req,
  input logic [2:0] external_wake_irq_inputs,
  input logic [2:0] irq_unmasked,
  input logic       in_nmi_service,
  input logic [7:0] power_save_control_reg,
  input logic [7:0] power_save_mode_reg,
  input logic       wake_ack,
  input logic       wake_ack_nmi,
  input logic       wake_branch,
  input logic       wake_pending,
  input logic       idle_active,
  input logic       osc_pll_enable,
  input logic       sys_clk_enable,
  input logic       cpu_halt,
  input logic       bus_float,
  input logic       strobes_force_high,
  input logic       hold_ack_force_high,
  input logic       hold_wait_ignore,
  input logic       sdram_ctl_keep_running,
  input logic       sdram_clock_enable,
  input logic       sdram_clock_gate,
  input logic       system_clock_gate
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire mask_clr = power_save_control_reg[1:0] == 2'b00;
  // Entry is only judged from a settled run state, never in the cycle after a wake
  property p_enter; ((mode_wr && wr_data == idle_pkg::MODE_IDLE_CODE) ||
    (ctrl_wr && wr_data[idle_pkg::IDLE_REQ_BIT])) && !idle_active
    && !$past(idle_active) && !$past(idle_active, 2) |=> idle_active; endproperty
  a_enter: assert property (p_enter) else $error("idle not entered");
  property p_clk; osc_pll_enable && (sys_clk_enable == !idle_active)
    && (cpu_halt == idle_active); endproperty
  a_clk: assert property (p_clk) else $error("clock gating wrong");
  property p_pins; idle_active |-> bus_float && strobes_force_high && hold_ack_force_high
    && hold_wait_ignore && !sdram_clock_enable && !sdram_clock_gate && !system_clock_gate
    && sdram_ctl_keep_running;
  endproperty
  a_pins: assert property (p_pins) else $error("idle pin state wrong");
  property p_nmi; $rose(nmi_req) && idle_active && mask_clr && !in_nmi_service |->
    ##[1:3] !idle_active && wake_ack && wake_ack_nmi && wake_branch; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi wake wrong");
  property p_masked; idle_active && !mask_clr |=> idle_active; endproperty
  a_masked: assert property (p_masked) else $error("masked idle left");
  property p_nmisvc; $rose(nmi_req) && idle_active && mask_clr && in_nmi_service |->
    ##[1:3] !idle_active && wake_pending && !wake_ack; endproperty
  a_nmisvc: assert property (p_nmisvc) else $error("nmi service wake wrong");
  property p_clear; $fell(idle_active) |-> power_save_mode_reg == 8'h00
    && !power_save_control_reg[2]; endproperty
  a_clear: assert property (p_clear) else $error("request not cleared");
  property p_cause; $fell(idle_active) |-> $past(nmi_req, 2)
    || ($past(external_wake_irq_inputs, 2) & $past(irq_unmasked, 2)) != 3'h0; endproperty
  a_cause: assert property (p_cause) else $error("idle left without cause");
endmodule : idle_chk

bind idle_mode_power_controller idle_chk idle_chk_i (.core_clk, .resetn, .ctrl_wr, .mode_wr,
  .wr_data, .nmi_req, .external_wake_irq_inputs, .irq_unmasked, .in_nmi_service,
  .power_save_control_reg, .power_save_mode_reg, .wake_ack, .wake_ack_nmi, .wake_branch,
  .wake_pending, .idle_active, .osc_pll_enable, .sys_clk_enable, .cpu_halt, .bus_float,
  .strobes_force_high, .hold_ack_force_high, .hold_wait_ignore, .sdram_ctl_keep_running,
  .sdram_clock_enable,
  .sdram_clock_gate, .system_clock_gate);

// [tb/irq_src_model.sv]
`timescale 1ns/1ps
// ==========
// Interrupt sources
module irq_src_model (
  input  logic       core_clk,
  input  logic       resetn,
  input  logic       fire_nmi,
  input  logic [2:0] fire_irq,
  input  logic       wake_ack,
  input  logic       wake_pending,
  output logic       nmi_req,
  output logic [2:0] irq_out
);
  // Levels stand until answered, so a slow wake path still sees them
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      nmi_req <= 1'b0;
      irq_out <= 3'h0;
    end else if (wake_ack || wake_pending) begin
      nmi_req <= 1'b0;
      irq_out <= 3'h0;
    end else begin
      nmi_req <= nmi_req | fire_nmi;
      irq_out <= irq_out | fire_irq;
    end
  end
endmodule : irq_src_model

// [tb/idle_mode_power_controller_tb.sv]
`timescale 1ns/1ps
// ==========
// Idle bench
module idle_mode_power_controller_tb;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        ctrl_wr = 1'b0;
  logic        mode_wr = 1'b0;
  logic        idle_by_sw = 1'b0;
  logic [7:0]  wr_data = 8'h00;
  logic [2:0]  irq_unmasked = 3'h7;
  logic [11:0] irq_prio = 12'h715;
  logic [3:0]  cur_service_prio = 4'h3;
  logic        in_maskable_service = 1'b0;
  logic        in_nmi_service = 1'b0;
  logic        irq_enabled_state = 1'b1;
  logic        fire_nmi = 1'b0;
  logic [2:0]  fire_irq = 3'h0;
  logic        nmi_req, wake_ack, wake_branch, wake_pending, idle_active, sys_clk_enable;
  logic [2:0]  external_wake_irq_inputs;
  logic [1:0]  wake_ack_idx;
  logic [7:0]  power_save_control_reg, power_save_mode_reg;
  int          errors = 0;
  int          tests_run = 0;
  always #5 core_clk = ~core_clk;
  irq_src_model irq_src_model_i (.core_clk, .resetn, .fire_nmi, .fire_irq, .wake_ack,
    .wake_pending, .nmi_req, .irq_out(external_wake_irq_inputs));
  idle_mode_power_controller idle_mode_power_controller_i (.core_clk, .resetn, .ctrl_wr,
    .mode_wr, .wr_data, .power_save_control_reg, .power_save_mode_reg, .nmi_req,
    .external_wake_irq_inputs, .irq_unmasked, .irq_prio, .cur_service_prio,
    .in_maskable_service, .in_nmi_service, .irq_enabled_state, .wake_ack, .wake_ack_nmi(),
    .wake_ack_idx, .wake_branch, .wake_pending, .osc_pll_enable(), .sys_clk_enable,
    .cpu_halt(), .idle_active, .bus_float(), .strobes_force_high(), .hold_ack_force_high(),
    .hold_wait_ignore(), .sdram_ctl_keep_running(), .sdram_clock_enable(),
    .sdram_clock_gate(), .system_clock_gate());
  task automatic end_of_test;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic c, input string m);
    tests_run++;
    if (c !== 1'b1) begin
      errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  // Enter idle, raise one source, expect acknowledge or pending
  task automatic wake(input logic mode, input logic [7:0] d, input logic nmi,
                      input logic [1:0] idx, input logic ack);
    int n;
    @(negedge core_clk);
    idle_by_sw = mode;
    mode_wr = mode;
    ctrl_wr = !mode;
    wr_data = d;
    @(negedge core_clk);
    ctrl_wr = 1'b0;
    mode_wr = 1'b0;
    chk(idle_active === 1'b1, "not idle");
    fire_nmi = nmi;
    fire_irq = nmi ? 3'h0 : 3'h1 << idx;
    @(negedge core_clk);
    fire_nmi = 1'b0;
    fire_irq = 3'h0;
    n = 0;
    while (wake_ack !== 1'b1 && wake_pending !== 1'b1 && n < 8) begin
      @(negedge core_clk);
      n++;
    end
    if (n == 8) begin
      chk(1'b0, "wake timeout");
      end_of_test();
    end
    chk(idle_active === 1'b0 && sys_clk_enable === 1'b1, "still idle");
    chk(wake_ack === ack && wake_pending === !ack && wake_branch === ack, "answer");
    if (ack && !nmi) chk(wake_ack_idx === idx, "index");
    if (ack && nmi) idle_by_sw = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask : wake
  task automatic t_sources;
    wake(1'b1, 8'h01, 1'b1, 2'd0, 1'b1);
    for (int i = 0; i < 3; i++) wake(1'b0, 8'h04, 1'b0, 2'(i), 1'b1);
    irq_enabled_state = 1'b0;
    wake(1'b0, 8'h04, 1'b0, 2'd1, 1'b0);
    irq_enabled_state = 1'b1;
  endtask : t_sources
  task automatic t_service;
    in_maskable_service = 1'b1;
    wake(1'b0, 8'h04, 1'b0, 2'd0, 1'b0);
    wake(1'b0, 8'h04, 1'b0, 2'd1, 1'b1);
    wake(1'b1, 8'h01, 1'b1, 2'd0, 1'b1);
    in_maskable_service = 1'b0;
    in_nmi_service = 1'b1;
    wake(1'b1, 8'h01, 1'b1, 2'd0, 1'b0);
    in_nmi_service = 1'b0;
  endtask : t_service
  // A source masked at the controller must not wake; unmasking it then does
  task automatic t_irq_mask;
    irq_unmasked = 3'h6;
    @(negedge core_clk);
    ctrl_wr = 1'b1;
    wr_data = 8'h04;
    @(negedge core_clk);
    ctrl_wr = 1'b0;
    fire_irq = 3'h1;
    @(negedge core_clk);
    fire_irq = 3'h0;
    repeat (6) @(negedge core_clk);
    chk(idle_active === 1'b1, "masked source woke");
    irq_unmasked = 3'h7;
    repeat (2) @(negedge core_clk);
    chk(idle_active === 1'b0 && wake_ack === 1'b1 && wake_ack_idx === 2'd0, "unmask");
    repeat (3) @(negedge core_clk);
  endtask : t_irq_mask
  // One mask bit alone must still block both kinds of wake
  task automatic t_masked;
    @(negedge core_clk);
    ctrl_wr = 1'b1;
    wr_data = 8'h05;
    @(negedge core_clk);
    ctrl_wr = 1'b0;
    fire_nmi = 1'b1;
    fire_irq = 3'h7;
    @(negedge core_clk);
    fire_nmi = 1'b0;
    fire_irq = 3'h0;
    repeat (6) @(negedge core_clk);
    chk(idle_active === 1'b1, "masked wake");
    resetn = 1'b0;
    @(negedge core_clk);
    chk(idle_active === 1'b0 && power_save_control_reg === 8'h00, "reset exit");
    resetn = 1'b1;
  endtask : t_masked
  initial begin
    repeat (10) @(negedge core_clk);
    resetn = 1'b1;
    chk(power_save_control_reg === 8'h00 && power_save_mode_reg === 8'h00, "reset");
    t_sources();
    t_service();
    t_irq_mask();
    t_masked();
    t_sources();
    end_of_test();
  end
endmodule : idle_mode_power_controller_tb
